// [shared/psc_regs.vh]
// register field layout, reset values and codes of the speed-up and test control words
`ifndef PSC_REGS_VH
`define PSC_REGS_VH
`define PSC_SEL_SPEEDUP 4'hD
`define PSC_SEL_TEST 4'hF
`define PSC_SEL_LSB 0
`define PSC_SEL_MSB 3
`define PSC_TOC_LSB 4
`define PSC_TOC_MSB 17
`define PSC_CPF_LSB 18
`define PSC_CPF_MSB 21
`define PSC_SLIP_LSB 22
`define PSC_SLIP_MSB 23
`define PSC_PREDIV_BIT 4
`define PSC_AUXRST_BIT 5
`define PSC_MAINRST_BIT 6
`define PSC_MAINTRI_BIT 7
`define PSC_AUXTRI_BIT 8
`define PSC_TOC_RST 14'h0000
`define PSC_CPF_RST 4'h0
`define PSC_SLIP_RST 2'h0
`define PSC_TOC_HIZ 14'h0000
`define PSC_TOC_MANUAL 14'h0001
`define PSC_TOC_LOW 14'h0002
`define PSC_TOC_HIGH 14'h0003
`define PSC_TOC_AUTO_MIN 14'h0004
`define PSC_LD_DIV 2'h3
`endif

// [core/psc_timeout_counter.v]
// speed-up time-out counter, counts main-loop comparison cycles
`timescale 1ns/1ps
`default_nettype none
module psc_timeout_counter (
  input wire mclk,
  input wire rst_n,
  input wire start,
  input wire [13:0] timeout,
  input wire cmpTick,
  output wire active
);
  reg [14:0] count_q;
  reg [14:0] count_d;

  // load twice the time-out on start, count down on each comparison cycle
  always @* begin
    count_d = count_q;
    if (start) begin
      count_d = {timeout, 1'b0}; // [R4]
    end else if (cmpTick && (count_q != 15'h0000)) begin
      count_d = count_q - 15'h0001;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      count_q <= 15'h0000;
    end else begin
      count_q <= count_d;
    end
  end

  assign active = (count_q != 15'h0000);
endmodule
`default_nettype wire

// [core/psc_speedup_control.v]
// speed-up, slip reduction, lock-detect and counter test control words
//
// Operation
// R1: time-out 0, 2 or 3 disables speed-up; pin hi-z for 0, low for 2, high for 3.
// R2: time-out 1 drives pin low and forces speed-up on without time-out.
// R3: time-out 4..16383 enables automatic speed-up; pin shows speed-up state.
// R4: automatic speed-up lasts twice the time-out in comparison cycles.
// R5: speed-up pump current is code plus one times unit current.
// R6: slip reduction code 0,1,2,3 gives sample factor 1, 1/2, 1/4, 1/16.
// R7: pre-divide bit divides main comparison rate by 4 for lock detect.
// R8: host should set pre-divide above 20 MHz main comparison with lock detect.
// R9: auxiliary clear bit resets auxiliary counters and floats auxiliary pump.
// R10: main clear bit resets main counters and floats main pump.
// R11: counter reset is applied automatically at every power-up.
// R12: main float bit floats main pump while counters keep running.
// R13: auxiliary float bit floats auxiliary pump while counters keep running.
// R14: host keeps clear bits low in normal operation.
// R15: frequency write starts time-out; speed-up settings apply while counting.
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
module psc_speedup_control (
  input wire mclk,
  input wire rst_n,
  input wire wordStrobe,
  input wire [23:0] wordData,
  input wire freqWordWrite,
  input wire powerUp,
  input wire mainCmpTick,
  input wire [3:0] steadyPumpCode,
  output reg speedupPinOut,
  output reg speedupPinOe_n,
  output reg speedupActive,
  output reg [4:0] pumpMultiple,
  output reg [4:0] sampleDivide,
  output reg lockDetTick,
  output reg mainCounterReset,
  output reg auxCounterReset,
  output reg mainPumpFloat,
  output reg auxPumpFloat
);
  reg [13:0] timeout_q;
  reg [3:0] pumpCode_q;
  reg [1:0] slipCode_q;
  reg prediv_q;
  reg auxClear_q;
  reg mainClear_q;
  reg mainTri_q;
  reg auxTri_q;
  reg puReset_q;
  reg [1:0] ldCount_q;
  wire timerActive;
  wire autoMode;
  wire manualMode;
  wire speedupOn;
  wire speedWordTake;
  wire testWordTake;

  // decode the slip reduction code into a divide factor
  function [4:0] slipFactor;
    input [1:0] code;
    begin
      case (code)
        2'h0: slipFactor = 5'h01; // [R6]
        2'h1: slipFactor = 5'h02;
        2'h2: slipFactor = 5'h04;
        default: slipFactor = 5'h10;
      endcase
    end
  endfunction

  // turn a pump code into its current multiple, 1x through 16x
  function [4:0] pumpFactor;
    input [3:0] code;
    begin
      pumpFactor = {1'b0, code} + 5'h01; // [R5]
    end
  endfunction

  // true when the select bits of a word carry the given code
  function selIs;
    input [23:0] word;
    input [3:0] code;
    begin
      selIs = (word[`PSC_SEL_MSB:`PSC_SEL_LSB] == code);
    end
  endfunction

  // a word is taken on its strobe when its select bits match
  assign speedWordTake = wordStrobe & selIs(wordData, `PSC_SEL_SPEEDUP);
  assign testWordTake = wordStrobe & selIs(wordData, `PSC_SEL_TEST);

  // capture the speed-up word: time-out, pump code and slip code
  always @(posedge mclk) begin
    if (!rst_n) begin
      timeout_q <= `PSC_TOC_RST;
      pumpCode_q <= `PSC_CPF_RST;
      slipCode_q <= `PSC_SLIP_RST;
    end else if (speedWordTake) begin
      timeout_q <= wordData[`PSC_TOC_MSB:`PSC_TOC_LSB];
      pumpCode_q <= wordData[`PSC_CPF_MSB:`PSC_CPF_LSB];
      slipCode_q <= wordData[`PSC_SLIP_MSB:`PSC_SLIP_LSB];
    end
  end

  // capture the test word; clear and float bits default to normal use
  always @(posedge mclk) begin
    if (!rst_n) begin
      prediv_q <= 1'b0;
      auxClear_q <= 1'b0; // [R9]
      mainClear_q <= 1'b0; // [R10]
      mainTri_q <= 1'b0; // [R12]
      auxTri_q <= 1'b0; // [R13]
    end else if (testWordTake) begin
      prediv_q <= wordData[`PSC_PREDIV_BIT];
      auxClear_q <= wordData[`PSC_AUXRST_BIT];
      mainClear_q <= wordData[`PSC_MAINRST_BIT];
      mainTri_q <= wordData[`PSC_MAINTRI_BIT];
      auxTri_q <= wordData[`PSC_AUXTRI_BIT];
    end
  end

  // one-cycle counter reset pulse on each power-up; reset itself counts
  // as a power-up, so both loops leave reset with counters cleared
  always @(posedge mclk) begin
    if (!rst_n) begin
      puReset_q <= 1'b1;
    end else begin
      puReset_q <= powerUp; // [R11]
    end
  end

  assign autoMode = (timeout_q >= `PSC_TOC_AUTO_MIN); // [R3]
  assign manualMode = (timeout_q == `PSC_TOC_MANUAL); // [R2]
  assign speedupOn = manualMode | (autoMode & timerActive); // [R15]

  // time-out counter restarted by each frequency word in automatic mode
  // outside automatic mode the count is not restarted but still runs down on ticks, and its state is unused
  psc_timeout_counter timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(freqWordWrite & autoMode), // [R15]
    .timeout(timeout_q),
    .cmpTick(mainCmpTick),
    .active(timerActive)
  );

  // comparison ticks counted modulo four for the lock detect divider
  always @(posedge mclk) begin
    if (!rst_n) begin
      ldCount_q <= 2'h0;
    end else if (mainCmpTick) begin
      ldCount_q <= ldCount_q + 2'h1;
    end
  end

  // lock detect tick: every tick, or every fourth when pre-divided
  always @(posedge mclk) begin
    if (!rst_n) begin
      lockDetTick <= 1'b0;
    end else begin
      lockDetTick <= mainCmpTick &
        (!prediv_q || (ldCount_q == `PSC_LD_DIV)); // [R7]
    end
  end

  // speed-up pin: dedicated in automatic mode, general-purpose otherwise
  always @(posedge mclk) begin
    if (!rst_n) begin
      speedupPinOut <= 1'b0;
      speedupPinOe_n <= 1'b1;
    end else if (autoMode) begin
      speedupPinOut <= timerActive; // [R3]
      speedupPinOe_n <= 1'b0;
    end else begin
      case (timeout_q)
        `PSC_TOC_HIZ: begin
          speedupPinOut <= 1'b0; // [R1]
          speedupPinOe_n <= 1'b1;
        end
        `PSC_TOC_MANUAL: begin
          speedupPinOut <= 1'b0; // [R2]
          speedupPinOe_n <= 1'b0;
        end
        `PSC_TOC_LOW: begin
          speedupPinOut <= 1'b0; // [R1]
          speedupPinOe_n <= 1'b0;
        end
        default: begin
          speedupPinOut <= 1'b1; // [R1]
          speedupPinOe_n <= 1'b0;
        end
      endcase
    end
  end

  // speed-up pump current and slip reduction follow the speed-up state
  always @(posedge mclk) begin
    if (!rst_n) begin
      speedupActive <= 1'b0;
      pumpMultiple <= 5'h01;
      sampleDivide <= 5'h01;
    end else begin
      speedupActive <= speedupOn; // [R2] [R15]
      pumpMultiple <= speedupOn ? pumpFactor(pumpCode_q)
        : pumpFactor(steadyPumpCode); // [R5]
      sampleDivide <= speedupOn ? slipFactor(slipCode_q) : 5'h01; // [R6]
    end
  end

  // counter resets and pump floats, also raised by a power-up
  always @(posedge mclk) begin
    if (!rst_n) begin
      mainCounterReset <= 1'b1;
      auxCounterReset <= 1'b1;
      mainPumpFloat <= 1'b1;
      auxPumpFloat <= 1'b1;
    end else begin
      mainCounterReset <= mainClear_q | puReset_q; // [R10] [R11]
      auxCounterReset <= auxClear_q | puReset_q; // [R9] [R11]
      mainPumpFloat <= mainClear_q | mainTri_q | puReset_q; // [R12]
      auxPumpFloat <= auxClear_q | auxTri_q | puReset_q; // [R13]
    end
  end
endmodule
`default_nettype wire

// [verif/psc_speedup_control_sva.sv]
// assertions on the speed-up and test control ports
`timescale 1ns/1ps
`default_nettype none
module psc_speedup_control_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wordStrobe,
  input wire logic [23:0] wordData,
  input wire logic powerUp,
  input wire logic speedupPinOut,
  input wire logic speedupPinOe_n,
  input wire logic speedupActive,
  input wire logic [4:0] pumpMultiple,
  input wire logic [4:0] sampleDivide,
  input wire logic mainCounterReset,
  input wire logic auxCounterReset,
  input wire logic mainPumpFloat,
  input wire logic auxPumpFloat
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // decoded word takes and expected test bits
  wire [13:0] toc = wordData[17:4];
  wire spd = wordStrobe && wordData[3:0] == 4'hD;
  wire tst = wordStrobe && wordData[3:0] == 4'hF;
  wire [1:0] pinSt = {speedupPinOe_n, speedupPinOut};
  wire [1:0] mainExp = {wordData[6], wordData[6] | wordData[7]};
  wire [1:0] auxExp = {wordData[5], wordData[5] | wordData[8]};
  AST_HIZ: assert property (spd && toc == 14'h0 |-> ##2 pinSt[1])
    else $error("pin not released");
  AST_LOW: assert property (spd && toc == 14'h2 |-> ##2 pinSt == 2'h0)
    else $error("pin not low");
  AST_HIGH: assert property (spd && toc == 14'h3 |-> ##2 pinSt == 2'h1)
    else $error("pin not high");
  AST_MAN: assert property (spd && toc == 14'h1
    && wordData[21:18] == 4'hF |-> ##2 speedupActive && pumpMultiple == 5'h10)
    else $error("manual mode wrong");
  AST_SLIP: assert property (spd && toc == 14'h1
    && wordData[23:22] == 2'h3 |-> ##2 sampleDivide == 5'h10)
    else $error("slip divide wrong");
  AST_MCLR: assert property (tst |-> ##2
    {mainCounterReset, mainPumpFloat} == $past(mainExp, 2))
    else $error("main test bits wrong");
  AST_ACLR: assert property (tst |-> ##2
    {auxCounterReset, auxPumpFloat} == $past(auxExp, 2))
    else $error("aux test bits wrong");
  AST_PUP: assert property (powerUp |-> ##[1:2] mainCounterReset
    && auxCounterReset)
    else $error("no power-up reset");
  cover property (speedupActive && pinSt == 2'h1);
  cover property (mainPumpFloat && !mainCounterReset);
  cover property (sampleDivide == 5'h10);
endmodule
bind psc_speedup_control psc_speedup_control_sva chk (.mclk, .rst_n,
  .wordStrobe, .wordData, .powerUp, .speedupPinOut, .speedupPinOe_n,
  .speedupActive, .pumpMultiple, .sampleDivide, .mainCounterReset,
  .auxCounterReset, .mainPumpFloat, .auxPumpFloat);
`default_nettype wire

// [verif/psc_host_model.sv]
// host model handing whole control words to the block
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
  input wire logic mclk,
  output logic wordStrobe,
  output logic [23:0] wordData,
  output logic freqWordWrite
);
  initial begin
    wordStrobe <= 1'b0;
    wordData <= 24'h000000;
    freqWordWrite <= 1'b0;
  end
  // one word per strobe, data scrambled once released
  task send(input logic [23:0] w);
    @(posedge mclk);
    wordStrobe <= 1'b1;
    wordData <= w;
    @(posedge mclk);
    wordStrobe <= 1'b0;
    wordData <= ~w;
  endtask
  // one-cycle frequency word write
  task freq();
    @(posedge mclk);
    freqWordWrite <= 1'b1;
    @(posedge mclk);
    freqWordWrite <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the speed-up and test control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic powerUp = 1'b0;
  logic mainCmpTick = 1'b0;
  logic [3:0] steadyPumpCode = 4'h3;
  logic wordStrobe, freqWordWrite, speedupPinOut, speedupPinOe_n;
  logic speedupActive, lockDetTick, mainCounterReset, auxCounterReset;
  logic mainPumpFloat, auxPumpFloat;
  logic [23:0] wordData;
  logic [4:0] pumpMultiple, sampleDivide, e;
  int num_errors = 0;
  int num_checks = 0;
  int ldCount = 0;
  int i;
  wire [4:0] pin = {2'h0, speedupActive, speedupPinOe_n, speedupPinOut};
  wire [4:0] clr = {1'b0, mainCounterReset, auxCounterReset,
    mainPumpFloat, auxPumpFloat};
  psc_host_model host (.mclk, .wordStrobe, .wordData, .freqWordWrite);
  psc_speedup_control dut (.mclk, .rst_n, .wordStrobe, .wordData,
    .freqWordWrite, .powerUp, .mainCmpTick, .steadyPumpCode, .speedupPinOut,
    .speedupPinOe_n, .speedupActive, .pumpMultiple, .sampleDivide,
    .lockDetTick, .mainCounterReset, .auxCounterReset, .mainPumpFloat,
    .auxPumpFloat);
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) ldCount <= ldCount + int'(lockDetTick);
  task chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // write a word and wait until its outputs have landed
  task put(input logic [23:0] w);
    host.send(w);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // comparison ticks two cycles apart
  task tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      mainCmpTick <= 1'b1;
      @(posedge mclk);
      mainCmpTick <= 1'b0;
    end
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task print_verdict();
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the run needs about 120 cycles
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("rstClr", 5'h0F, clr);
    chk("rstPin", 5'h02, pin);
    chk("rstPump", 5'h04, pumpMultiple);
    repeat (2) @(posedge mclk);
    put(24'h00000D);
    chk("hiz", 5'h02, pin & 5'h06);
    put(24'h00002D);
    chk("low", 5'h00, pin);
    put(24'h00003D);
    chk("high", 5'h01, pin);
    put(24'h00002E);
    chk("ignored", 5'h01, pin);
    host.freq();
    for (i = 0; i < 4; i++) begin
      put({i[1:0], 4'hF, 14'h0001, 4'hD});
      chk("slip", 5'(1 << (i == 3 ? 4 : i)), sampleDivide);
      chk("pumpMan", 5'h10, pumpMultiple);
      chk("manual", 5'h04, pin);
    end
    put({2'h0, 4'h7, 14'h0004, 4'hD});
    chk("autoIdle", 5'h00, pin);
    host.freq();
    repeat (2) @(posedge mclk);
    #1;
    chk("autoOn", 5'h05, pin);
    chk("pumpAuto", 5'h08, pumpMultiple);
    tick(7);
    chk("auto7", 5'h05, pin);
    tick(1);
    chk("auto8", 5'h00, pin);
    chk("pumpSteady", 5'h04, pumpMultiple);
    put(24'h00001F);
    i = ldCount;
    tick(8);
    chk("ldDiv", 5'h02, 5'(ldCount - i));
    for (i = 1; i < 16; i = i * 2) begin
      put({15'h0, i[3:0], 1'b0, 4'hF});
      e = {1'b0, i[1], i[0], i[1] | i[2], i[0] | i[3]};
      chk("testBits", e, clr);
    end
    put(24'h00000F);
    @(posedge mclk);
    powerUp <= 1'b1;
    @(posedge mclk);
    powerUp <= 1'b0;
    @(posedge mclk);
    #1;
    chk("powerUp", 5'h0F, clr);
    @(posedge mclk);
    #1;
    chk("pupEnd", 5'h00, clr);
    repeat (4) @(posedge mclk);
    print_verdict();
  end
endmodule
`default_nettype wire
